// File: design/menu_nav_pkg.sv
// Purpose: Shared constants and types for the multimeter menu navigator
// Assumes: One system clock at 250 MHz
// Notes: Item counts follow the menu listing

package menu_nav_pkg;

   localparam int HEAD_W = 3;
   localparam int ITEM_W = 4;
   localparam int HIST_W = 3;
   localparam int OVL_W = 3;

   // Headings in display order
   localparam logic [HEAD_W-1:0] HEAD_BASIC = 3'h0;
   localparam logic [HEAD_W-1:0] HEAD_PA = 3'h1;
   localparam logic [HEAD_W-1:0] HEAD_IPA = 3'h2;
   localparam logic [HEAD_W-1:0] HEAD_PREAMP = 3'h3;
   localparam logic [HEAD_W-1:0] HEAD_CTRL = 3'h4;
   localparam logic [HEAD_W-1:0] HEAD_OVL = 3'h5;
   localparam logic [HEAD_W-1:0] HEAD_CLOCK = 3'h6;
   localparam logic [HEAD_W-1:0] HEAD_LAST = 3'h6;

   // Sub-item counts per heading
   localparam logic [ITEM_W-1:0] N_BASIC = 4'h7;
   localparam logic [ITEM_W-1:0] N_PA = 4'he;
   localparam logic [ITEM_W-1:0] N_IPA = 4'h6;
   localparam logic [ITEM_W-1:0] N_PREAMP = 4'h4;
   localparam logic [ITEM_W-1:0] N_CTRL = 4'h9;
   localparam logic [ITEM_W-1:0] N_OVL = 4'h7;
   localparam logic [ITEM_W-1:0] N_CLOCK = 4'h6;

   // Overload history depth
   localparam logic [HIST_W-1:0] HIST_LAST = 3'h7;

   // Reset values
   localparam logic [HEAD_W-1:0] HEAD_RST = 3'h0;
   localparam logic [ITEM_W-1:0] ITEM_RST = 4'h0;
   localparam logic [HIST_W-1:0] HIST_RST = 3'h0;

   typedef enum logic [1:0] {
      VIEW_HEAD = 2'b00,
      VIEW_ITEM = 2'b01,
      VIEW_HIST = 2'b11
   } view_type;

endpackage : menu_nav_pkg

// File: design/menu_nav.sv
// Purpose: Front-panel multimeter menu navigation state machine
// Assumes: Keys are raw pins, debounced elsewhere; one press is one edge
// Notes: Overload memory itself lives outside; this block issues clear pulses

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Reset shows basic readings heading
// - Select on basic shows plate current
// - Return from sub-item goes to owner heading
// - Return from heading goes to basic readings
// - Select on any heading but clock shows first sub-item
// - Next on heading advances heading
// - Next on sub-item advances sub-item
// - Previous on heading steps heading back
// - Previous on sub-item steps sub-item back
// - Heading order basic, PA, driver, ... clock
// - Select on overloads shows an overload category
// - Two unlabelled presses clear that category
// - Next/previous move between overload categories
// - Select on category shows latest event
// - Previous in history shows older event
module menu_nav
   import menu_nav_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // Pushbuttons, active high, asynchronous
   input wire logic KEY_SELECT_I,
   input wire logic KEY_NEXT_I,
   input wire logic KEY_PREV_I,
   input wire logic KEY_RETURN_I,
   input wire logic KEY_BLANK_I,
   // Display position
   output logic [1:0] VIEW_O,
   output logic [HEAD_W-1:0] HEAD_O,
   output logic [ITEM_W-1:0] ITEM_O,
   output logic [HIST_W-1:0] HIST_O,
   // Overload memory clear
   output logic CLR_OVL_O,
   output logic [OVL_W-1:0] CLR_CAT_O
);

   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   logic [4:0] prev_ff;
   logic [4:0] press;
   logic p_sel, p_next, p_prev, p_ret, p_blank;
   view_type view_ff;
   logic [HEAD_W-1:0] head_ff;
   logic [ITEM_W-1:0] item_ff;
   logic [HIST_W-1:0] hist_ff;
   logic blank_arm_ff;
   logic clr_ff;
   logic [OVL_W-1:0] clr_cat_ff;
   logic [ITEM_W-1:0] last_item;

   function automatic logic [ITEM_W-1:0] item_count(input logic [HEAD_W-1:0] h);
      unique case (h)
         HEAD_BASIC: item_count = N_BASIC;
         HEAD_PA: item_count = N_PA;
         HEAD_IPA: item_count = N_IPA;
         HEAD_PREAMP: item_count = N_PREAMP;
         HEAD_CTRL: item_count = N_CTRL;
         HEAD_OVL: item_count = N_OVL;
         default: item_count = N_CLOCK;
      endcase
   endfunction : item_count

   // Two-stage synchroniser, then rising-edge detect on stage two
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         meta_ff <= 5'h00;
         sync_ff <= 5'h00;
         prev_ff <= 5'h00;
      end else begin
         meta_ff <= {KEY_BLANK_I, KEY_RETURN_I, KEY_PREV_I, KEY_NEXT_I, KEY_SELECT_I};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign press = sync_ff & ~prev_ff;
   // One key per cycle wins, in a fixed priority, so the view never splits
   assign p_ret = press[3];
   assign p_sel = press[0] & ~p_ret;
   assign p_next = press[1] & ~p_ret & ~press[0];
   assign p_prev = press[2] & ~p_ret & ~press[0] & ~press[1];
   assign p_blank = press[4] & ~(|press[3:0]);

   assign last_item = item_count(head_ff) - 4'h1;

   // Navigation
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         view_ff <= VIEW_HEAD;
         head_ff <= HEAD_RST;
         item_ff <= ITEM_RST;
         hist_ff <= HIST_RST;
      end else begin
         unique case (view_ff)
            VIEW_HEAD: begin
               if (p_ret) begin
                  head_ff <= HEAD_BASIC;
               end else if (p_sel && head_ff != HEAD_CLOCK) begin
                  // Clock-set behaviour is not modelled; select is ignored there
                  view_ff <= VIEW_ITEM;
                  item_ff <= ITEM_RST;
               end else if (p_next) begin
                  head_ff <= (head_ff == HEAD_LAST) ? HEAD_BASIC
                             : head_ff + 3'h1;
               end else if (p_prev) begin
                  head_ff <= (head_ff == HEAD_BASIC) ? HEAD_LAST
                             : head_ff - 3'h1;
               end
            end
            VIEW_ITEM: begin
               if (p_ret) begin
                  view_ff <= VIEW_HEAD;
               end else if (p_sel && head_ff == HEAD_OVL) begin
                  view_ff <= VIEW_HIST;
                  hist_ff <= HIST_RST;
               end else if (p_next) begin
                  item_ff <= (item_ff == last_item) ? ITEM_RST
                             : item_ff + 4'h1;
               end else if (p_prev) begin
                  item_ff <= (item_ff == ITEM_RST) ? last_item
                             : item_ff - 4'h1;
               end
            end
            VIEW_HIST: begin
               if (p_ret) begin
                  view_ff <= VIEW_ITEM;
               end else if (p_prev) begin
                  hist_ff <= (hist_ff == HIST_LAST) ? HIST_RST
                             : hist_ff + 3'h1;
               end else if (p_next) begin
                  hist_ff <= (hist_ff == HIST_RST) ? HIST_LAST : hist_ff - 3'h1;
               end
            end
            default: view_ff <= VIEW_HEAD;
         endcase
      end
   end

   // Overload clear: two unlabelled presses in a row while a category is shown
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         blank_arm_ff <= 1'b0;
         clr_ff <= 1'b0;
         clr_cat_ff <= 3'h0;
      end else begin
         clr_ff <= 1'b0;
         if (view_ff != VIEW_ITEM || head_ff != HEAD_OVL || (|press[3:0])) begin
            // Any other key or leaving the category disarms
            blank_arm_ff <= 1'b0;
         end else if (p_blank) begin
            if (blank_arm_ff) begin
               blank_arm_ff <= 1'b0;
               clr_ff <= 1'b1;
               clr_cat_ff <= item_ff[OVL_W-1:0];
            end else begin
               blank_arm_ff <= 1'b1;
            end
         end
      end
   end

   assign VIEW_O = view_ff;
   assign HEAD_O = head_ff;
   assign ITEM_O = item_ff;
   assign HIST_O = hist_ff;
   assign CLR_OVL_O = clr_ff;
   assign CLR_CAT_O = clr_cat_ff;

   property p_ret_head;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_HEAD && p_ret) |=> (head_ff == HEAD_BASIC && view_ff == VIEW_HEAD);
   endproperty
   a_ret_head: assert property (p_ret_head) else $error("Return from heading failed");

   property p_ret_item;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_ITEM && p_ret) |=> (view_ff == VIEW_HEAD && $stable(head_ff));
   endproperty
   a_ret_item: assert property (p_ret_item) else $error("Return from item failed");

   property p_sel_head;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_HEAD && p_sel && head_ff != HEAD_CLOCK)
         |=> (view_ff == VIEW_ITEM && item_ff == ITEM_RST);
   endproperty
   a_sel_head: assert property (p_sel_head) else $error("Select to first item failed");

   property p_next_head;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_HEAD && p_next && head_ff != HEAD_LAST)
         |=> head_ff == $past(head_ff) + 3'h1;
   endproperty
   a_next_head: assert property (p_next_head) else $error("Next heading failed");

   property p_prev_head_wrap;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_HEAD && p_prev && head_ff == HEAD_BASIC) |=> head_ff == HEAD_LAST;
   endproperty
   a_prev_head_wrap: assert property (p_prev_head_wrap) else $error("Heading wrap failed");

   property p_prev_head;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_HEAD && p_prev && head_ff != HEAD_BASIC)
         |=> head_ff == $past(head_ff) - 3'h1;
   endproperty
   a_prev_head: assert property (p_prev_head) else $error("Previous heading failed");

   property p_next_item;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_ITEM && p_next && item_ff != last_item)
         |=> item_ff == $past(item_ff) + 4'h1;
   endproperty
   a_next_item: assert property (p_next_item) else $error("Next item failed");

   property p_prev_item;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_ITEM && p_prev && item_ff == ITEM_RST) |=> item_ff == $past(last_item);
   endproperty
   a_prev_item: assert property (p_prev_item) else $error("Item wrap failed");

   sequence s_two_blank;
      (view_ff == VIEW_ITEM && head_ff == HEAD_OVL && p_blank && blank_arm_ff);
   endsequence
   property p_clear;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      s_two_blank |=> (CLR_OVL_O && CLR_CAT_O == $past(item_ff[OVL_W-1:0])) ##1 !CLR_OVL_O;
   endproperty
   a_clear: assert property (p_clear) else $error("Overload clear failed");

   property p_hist;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_ITEM && head_ff == HEAD_OVL && p_sel)
         |=> (view_ff == VIEW_HIST && hist_ff == HIST_RST);
   endproperty
   a_hist: assert property (p_hist) else $error("History entry failed");

   property p_hist_prev;
      @(posedge CLK_SYS_I) disable iff (RST_I)
      (view_ff == VIEW_HIST && p_prev && hist_ff != HIST_LAST)
         |=> hist_ff == $past(hist_ff) + 3'h1;
   endproperty
   a_hist_prev: assert property (p_hist_prev) else $error("Older event step failed");

endmodule : menu_nav

`default_nettype wire

// File: dv/key_operator.sv
// Purpose: Operator model pressing the front-panel keys
// Assumes: Keys are clean levels, high while held
// Notes: Key index 0 select, 1 next, 2 previous, 3 return, 4 unlabelled
`timescale 1ns/1ps
`default_nettype none
module key_operator (
   // Clock
   input wire logic clk_i,
   // Press request, sampled on the falling edge
   input wire logic go_i,
   input wire logic [2:0] key_i,
   // Key levels and end-of-press strobe
   output logic [4:0] keys_o,
   output logic done_o
);
   initial begin
      keys_o = 5'h00;
      done_o = 1'b0;
   end

   // Held past the synchroniser, then low long enough to re-arm
   always begin
      @(negedge clk_i);
      if (go_i) begin
         keys_o[key_i] = 1'b1;
         repeat (4) @(negedge clk_i);
         keys_o[key_i] = 1'b0;
         repeat (4) @(negedge clk_i);
         done_o = 1'b1;
         @(negedge clk_i);
         done_o = 1'b0;
      end
   end
endmodule : key_operator
`default_nettype wire

// File: dv/menu_nav_bench.sv
// Purpose: Self-checking bench for the menu navigator
// Assumes: Outputs settle three edges after a key rises
// Notes: Item index is masked in heading view, history outside history
`timescale 1ns/1ps
`default_nettype none
module menu_nav_bench;
   import menu_nav_pkg::*;
   localparam int NROWS = 27;
   logic clk_sys;
   logic rst;
   logic go;
   logic done;
   logic [2:0] key_sel;
   logic [4:0] keys;
   logic [1:0] view;
   logic [HEAD_W-1:0] head;
   logic [ITEM_W-1:0] item;
   logic [HIST_W-1:0] hist;
   logic clr;
   logic [OVL_W-1:0] cat;
   logic [OVL_W-1:0] cat_seen = 3'h0;
   logic [11:0] e;
   logic [11:0] m;
   int errors = 0;
   int n_checks = 0;
   int n_clr = 0;
   wire [11:0] pos = {view, head, item, hist};
   // Rows: key, view, heading, item, history
   logic [14:0] rows [NROWS] = '{
      {3'h1,2'h0,3'h1,4'h0,3'h0}, {3'h1,2'h0,3'h2,4'h0,3'h0}, {3'h1,2'h0,3'h3,4'h0,3'h0},
      {3'h1,2'h0,3'h4,4'h0,3'h0}, {3'h1,2'h0,3'h5,4'h0,3'h0}, {3'h1,2'h0,3'h6,4'h0,3'h0},
      {3'h1,2'h0,3'h0,4'h0,3'h0}, {3'h2,2'h0,3'h6,4'h0,3'h0}, {3'h3,2'h0,3'h0,4'h0,3'h0},
      {3'h0,2'h1,3'h0,4'h0,3'h0}, {3'h2,2'h1,3'h0,4'h6,3'h0}, {3'h1,2'h1,3'h0,4'h0,3'h0},
      {3'h1,2'h1,3'h0,4'h1,3'h0}, {3'h3,2'h0,3'h0,4'h0,3'h0}, {3'h2,2'h0,3'h6,4'h0,3'h0},
      {3'h2,2'h0,3'h5,4'h0,3'h0}, {3'h0,2'h1,3'h5,4'h0,3'h0}, {3'h1,2'h1,3'h5,4'h1,3'h0},
      {3'h2,2'h1,3'h5,4'h0,3'h0}, {3'h2,2'h1,3'h5,4'h6,3'h0}, {3'h1,2'h1,3'h5,4'h0,3'h0},
      {3'h1,2'h1,3'h5,4'h1,3'h0}, {3'h0,2'h3,3'h5,4'h1,3'h0}, {3'h2,2'h3,3'h5,4'h1,3'h1},
      {3'h2,2'h3,3'h5,4'h1,3'h2}, {3'h4,2'h3,3'h5,4'h1,3'h2}, {3'h3,2'h1,3'h5,4'h1,3'h0}};

   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   key_operator key_operator_i (.clk_i(clk_sys), .go_i(go), .key_i(key_sel), .keys_o(keys),
      .done_o(done));

   menu_nav menu_nav_i (.CLK_SYS_I(clk_sys), .RST_I(rst), .KEY_SELECT_I(keys[0]),
      .KEY_NEXT_I(keys[1]), .KEY_PREV_I(keys[2]), .KEY_RETURN_I(keys[3]),
      .KEY_BLANK_I(keys[4]), .VIEW_O(view), .HEAD_O(head), .ITEM_O(item),
      .HIST_O(hist), .CLR_OVL_O(clr), .CLR_CAT_O(cat));

   // Each high cycle counts, so a stretched pulse shows up as extra
   always @(negedge clk_sys) begin
      if (clr === 1'b1) begin
         n_clr++;
         cat_seen = cat;
      end
   end

   // Request raised by non-blocking assignment so the model sees it one edge later
   task automatic press(input logic [2:0] k);
      @(negedge clk_sys);
      key_sel <= k;
      go <= 1'b1;
      @(negedge clk_sys);
      go <= 1'b0;
      wait (done);
      @(negedge clk_sys);
   endtask : press

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   initial begin
      #20000;
      errors++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      go = 1'b0;
      key_sel = 3'h0;
      repeat (10) @(negedge clk_sys);
      check(pos, 12'h000);
      rst = 1'b0;
      @(negedge clk_sys);
      check(pos, 12'h000);
      for (int r = 0; r < NROWS; r++) begin
         press(rows[r][14:12]);
         e = rows[r][11:0];
         m = (e[11:10] == 2'h0) ? 12'hf80 : (e[11:10] == 2'h1) ? 12'hff8 : 12'hfff;
         check(pos & m, e & m);
      end
      // Pair of unlabelled presses on category 1 clears it once
      press(3'h4);
      press(3'h4);
      check(12'(n_clr), 12'h001);
      check({9'h000, cat_seen}, 12'h001);
      // A press of another key between breaks the pair
      press(3'h4);
      press(3'h1);
      press(3'h4);
      check(12'(n_clr), 12'h001);
      check(pos & 12'hff8, {2'h1, 3'h5, 4'h2, 3'h0});
      // Select at the clock heading is refused
      press(3'h3);
      press(3'h1);
      press(3'h0);
      check(pos & 12'hf80, {2'h0, 3'h6, 7'h00});
      // Reset in mid-run goes back to basic readings
      @(negedge clk_sys);
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      check(pos, 12'h000);
      wrap_up();
   end
endmodule : menu_nav_bench
`default_nettype wire
